/* File: verilog/ohc_top.sv */
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - Four independent counters, each with own state
// - Seconds, minutes to 59; hours to 596523
// - Counts only while enable is high, when the gate option is on
// - Count kept in retentive storage
// - Hours compared with reference every cycle
// - Direction high counts down, low up
// - Up: flag while hours at least reference
// - Down: flag while hours at most reference
// - Load rising edge copies preset into hours, capped at 596523
// - Clear held high forces count to zero
// - Stop, run, reprogram leave count unchanged
// - No counting while program not running
// - Zero flag high when count is zero
// - Gate option off ignores enable input
module ohc_top #(
    parameter int STEP_CYCLES = ohc_pkg::STEP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    localparam int N = ohc_pkg::NUM_CNT;

    // ==========================================================
    // Address decoding
    function automatic logic in_cnt(input logic [7:0] a);
        return (a[7:5] >= ohc_pkg::CNT_FIRST_SLOT) &&
            (a[7:5] <= ohc_pkg::CNT_LAST_SLOT);
    endfunction

    function automatic logic [1:0] cnt_idx(input logic [7:0] a);
        logic [2:0] s;
        s = a[7:5] - ohc_pkg::CNT_FIRST_SLOT;
        return s[1:0];
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (in_cnt(a)) begin
            ok = (a[4:0] == ohc_pkg::OFS_CTRL) ||
                (a[4:0] == ohc_pkg::OFS_PRESET) ||
                (a[4:0] == ohc_pkg::OFS_REF) ||
                (a[4:0] == ohc_pkg::OFS_HOURS) ||
                (a[4:0] == ohc_pkg::OFS_MINSEC) ||
                (a[4:0] == ohc_pkg::OFS_FLAGS);
        end else begin
            ok = (a == ohc_pkg::OFS_GCTRL) ||
                (a == ohc_pkg::OFS_IRQ_STAT) ||
                (a == ohc_pkg::OFS_IRQ_MASK);
        end
        return ok;
    endfunction

    function automatic logic [31:0] apply_strb(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0] s
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Registers and counter status
    logic run_reg;
    logic [4:0] ctrl_reg [N];
    logic [31:0] preset_reg [N];
    logic [31:0] ref_reg [N];
    logic [7:0] irq_stat_reg, irq_mask_reg, irq_event;
    logic [3:0] thr_q_reg, zero_q_reg;
    logic [19:0] hours_w [N];
    logic [5:0] min_w [N];
    logic [5:0] sec_w [N];
    logic [3:0] thr_w, zero_w;
    logic tick;

    ohc_tick #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick(tick)
    );

    ohc_cnt_if cif [N] ();

    for (genvar g = 0; g < N; g++) begin : g_cnt
        assign cif[g].enable = ctrl_reg[g][ohc_pkg::CTRL_EN_BIT];
        assign cif[g].dir = ctrl_reg[g][ohc_pkg::CTRL_DIR_BIT];
        assign cif[g].clear = ctrl_reg[g][ohc_pkg::CTRL_CLR_BIT];
        assign cif[g].load = ctrl_reg[g][ohc_pkg::CTRL_LOAD_BIT];
        assign cif[g].gate = ctrl_reg[g][ohc_pkg::CTRL_GATE_BIT];
        assign cif[g].run = run_reg;
        assign cif[g].tick = tick;
        assign cif[g].preset = preset_reg[g];
        assign cif[g].ref_val = ref_reg[g];
        assign hours_w[g] = cif[g].hours;
        assign min_w[g] = cif[g].minutes;
        assign sec_w[g] = cif[g].seconds;
        assign thr_w[g] = cif[g].thr;
        assign zero_w[g] = cif[g].zero;
        assign irq_event[2*g] = thr_w[g] & ~thr_q_reg[g];
        assign irq_event[2*g+1] = zero_w[g] & ~zero_q_reg[g];

        ohc_counter u_cnt (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .bus(cif[g])
        );
    end

    // ==========================================================
    // Write channel
    logic aw_held_reg, w_held_reg, bvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg;
    logic wr_fire, wr_ok, wr_cnt;
    logic [1:0] wr_idx;
    logic [4:0] wr_sub;

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_ok = is_mapped(aw_addr_reg);
    assign wr_cnt = in_cnt(aw_addr_reg);
    assign wr_idx = cnt_idx(aw_addr_reg);
    assign wr_sub = aw_addr_reg[4:0];

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= ohc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? ohc_pkg::RESP_OKAY : ohc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Writes to read-only counter words are accepted and dropped
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < N; i++) begin
                ctrl_reg[i] <= ohc_pkg::CTRL_RST;
                preset_reg[i] <= 32'h00000000;
                ref_reg[i] <= 32'h00000000;
            end
        end else if (wr_fire && wr_cnt) begin
            case (wr_sub)
                ohc_pkg::OFS_CTRL: begin
                    if (w_strb_reg[0]) begin
                        ctrl_reg[wr_idx] <= w_data_reg[4:0];
                    end
                end
                ohc_pkg::OFS_PRESET: begin
                    preset_reg[wr_idx] <= apply_strb(preset_reg[wr_idx],
                        w_data_reg, w_strb_reg);
                end
                ohc_pkg::OFS_REF: begin
                    ref_reg[wr_idx] <= apply_strb(ref_reg[wr_idx],
                        w_data_reg, w_strb_reg);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_reg <= 1'b0;
            irq_mask_reg <= ohc_pkg::IRQ_RST;
        end else if (wr_fire && w_strb_reg[0]) begin
            if (aw_addr_reg == ohc_pkg::OFS_GCTRL) begin
                run_reg <= w_data_reg[ohc_pkg::GCTRL_RUN_BIT];
            end
            if (aw_addr_reg == ohc_pkg::OFS_IRQ_MASK) begin
                irq_mask_reg <= w_data_reg[7:0];
            end
        end
    end

    // ==========================================================
    // Interrupts
    logic [7:0] irq_clr;

    assign irq_clr = (wr_fire && w_strb_reg[0] &&
        aw_addr_reg == ohc_pkg::OFS_IRQ_STAT) ? w_data_reg[7:0] : 8'h00;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            thr_q_reg <= 4'h0;
            zero_q_reg <= 4'h0;
            irq_stat_reg <= ohc_pkg::IRQ_RST;
        end else begin
            thr_q_reg <= thr_w;
            zero_q_reg <= zero_w;
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ==========================================================
    // Read channel
    logic rvalid_reg;
    logic [31:0] rdata_reg, rd_word;
    logic [1:0] rresp_reg;
    logic [1:0] rd_idx;

    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign rd_idx = cnt_idx(s_axi_araddr);

    always_comb begin
        rd_word = 32'h00000000;
        if (in_cnt(s_axi_araddr)) begin
            case (s_axi_araddr[4:0])
                ohc_pkg::OFS_CTRL: rd_word = {27'h0, ctrl_reg[rd_idx]};
                ohc_pkg::OFS_PRESET: rd_word = preset_reg[rd_idx];
                ohc_pkg::OFS_REF: rd_word = ref_reg[rd_idx];
                ohc_pkg::OFS_HOURS: rd_word = {12'h000, hours_w[rd_idx]};
                ohc_pkg::OFS_MINSEC: begin
                    rd_word[ohc_pkg::MIN_LSB +: 6] = min_w[rd_idx];
                    rd_word[5:0] = sec_w[rd_idx];
                end
                ohc_pkg::OFS_FLAGS: begin
                    rd_word[ohc_pkg::FLAG_THR_BIT] = thr_w[rd_idx];
                    rd_word[ohc_pkg::FLAG_ZERO_BIT] = zero_w[rd_idx];
                end
                default: rd_word = 32'h00000000;
            endcase
        end else begin
            case (s_axi_araddr)
                ohc_pkg::OFS_GCTRL: rd_word = {31'h0, run_reg};
                ohc_pkg::OFS_IRQ_STAT: rd_word = {24'h0, irq_stat_reg};
                ohc_pkg::OFS_IRQ_MASK: rd_word = {24'h0, irq_mask_reg};
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= ohc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= is_mapped(s_axi_araddr) ? ohc_pkg::RESP_OKAY :
                ohc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    bresp_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bresp_time_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wr_fire |=> s_axi_bvalid)
        else $error("write response late");
    irq_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        |(irq_event & irq_mask_reg) && !wr_fire |=> irq)
        else $error("unmasked event gave no interrupt");
    stat_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        irq_stat_reg[0] && irq_clr[0] == 1'b0 |=> irq_stat_reg[0])
        else $error("status bit lost without clear");
    run_stop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !run_reg && !ctrl_reg[0][ohc_pkg::CTRL_CLR_BIT] &&
        !ctrl_reg[0][ohc_pkg::CTRL_LOAD_BIT] |=> $stable(sec_w[0]))
        else $error("counter 0 moved while stopped");
endmodule

/* File: verilog/ohc_pkg.sv */
package ohc_pkg;
    // ==========================================================
    // Sizes and ranges
    localparam int NUM_CNT = 4;
    localparam int HOURS_W = 20;
    localparam int UNIT_W = 6;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [19:0] HOURS_MAX = 20'h91a2b;
    localparam logic [5:0] UNIT_MAX = 6'h3b;
    // ==========================================================
    // Timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int STEP_PERIOD_S = 1;
    localparam int STEP_CYCLES = CLK_FREQ_HZ * STEP_PERIOD_S;
    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_GCTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [2:0] CNT_FIRST_SLOT = 3'h1;
    localparam logic [2:0] CNT_LAST_SLOT = 3'h4;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_PRESET = 5'h04;
    localparam logic [4:0] OFS_REF = 5'h08;
    localparam logic [4:0] OFS_HOURS = 5'h0c;
    localparam logic [4:0] OFS_MINSEC = 5'h10;
    localparam logic [4:0] OFS_FLAGS = 5'h14;
    // ==========================================================
    // Fields and reset values
    localparam int CTRL_W = 5;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    localparam int CTRL_LOAD_BIT = 3;
    localparam int CTRL_GATE_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h10;
    localparam int GCTRL_RUN_BIT = 0;
    localparam int MIN_LSB = 8;
    localparam int FLAG_THR_BIT = 0;
    localparam int FLAG_ZERO_BIT = 1;
    localparam int IRQ_W = 2 * NUM_CNT;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: verilog/ohc_cnt_if.sv */
`timescale 1ns/100ps
interface ohc_cnt_if;
    logic enable, dir, clear, load, gate, run, tick;
    logic [31:0] preset;
    logic [31:0] ref_val;
    logic [19:0] hours;
    logic [5:0] minutes, seconds;
    logic thr, zero;
    modport ctl (
        output enable, dir, clear, load, gate, run, tick, preset, ref_val,
        input hours, minutes, seconds, thr, zero
    );
    modport cnt (
        input enable, dir, clear, load, gate, run, tick, preset, ref_val,
        output hours, minutes, seconds, thr, zero
    );
endinterface

/* File: verilog/ohc_tick.sv */
`timescale 1ns/100ps
module ohc_tick #(
    parameter int STEP_CYCLES = ohc_pkg::STEP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    output logic tick
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);
    logic [CW-1:0] div_reg;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
            tick <= 1'b0;
        end else if (div_reg == LAST) begin
            div_reg <= '0;
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

/* File: verilog/ohc_counter.sv */
`timescale 1ns/100ps
module ohc_counter (
    input wire logic clk_sys,
    input wire logic nrst,
    ohc_cnt_if.cnt bus
);
    logic [19:0] hours_reg, hours_next;
    logic [5:0] min_reg, min_next, sec_reg, sec_next;
    logic load_q_reg, thr_reg, zero_reg;
    logic load_rise, step, at_max, at_zero;
    logic [31:0] hours_ext;

    assign hours_ext = {12'h000, hours_reg};
    assign load_rise = bus.load & ~load_q_reg;
    assign step = bus.tick & bus.run & (bus.enable | ~bus.gate);
    assign at_max = (hours_reg == ohc_pkg::HOURS_MAX) &&
        (min_reg == ohc_pkg::UNIT_MAX) && (sec_reg == ohc_pkg::UNIT_MAX);
    assign at_zero = (hours_reg == 20'h00000) && (min_reg == 6'h00) &&
        (sec_reg == 6'h00);

    // ==========================================================
    // Next count
    always_comb begin
        hours_next = hours_reg;
        min_next = min_reg;
        sec_next = sec_reg;
        if (bus.clear) begin
            hours_next = '0;
            min_next = '0;
            sec_next = '0;
        end else if (load_rise) begin
            hours_next = (bus.preset > {12'h000, ohc_pkg::HOURS_MAX}) ?
                ohc_pkg::HOURS_MAX : bus.preset[19:0];
            min_next = '0;
            sec_next = '0;
        end else if (step && !bus.dir && !at_max) begin
            if (sec_reg == ohc_pkg::UNIT_MAX) begin
                sec_next = '0;
                if (min_reg == ohc_pkg::UNIT_MAX) begin
                    min_next = '0;
                    hours_next = hours_reg + 20'h00001;
                end else begin
                    min_next = min_reg + 6'h01;
                end
            end else begin
                sec_next = sec_reg + 6'h01;
            end
        end else if (step && bus.dir && !at_zero) begin
            if (sec_reg == 6'h00) begin
                sec_next = ohc_pkg::UNIT_MAX;
                if (min_reg == 6'h00) begin
                    min_next = ohc_pkg::UNIT_MAX;
                    hours_next = hours_reg - 20'h00001;
                end else begin
                    min_next = min_reg - 6'h01;
                end
            end else begin
                sec_next = sec_reg - 6'h01;
            end
        end
    end

    // Retained count: system reset leaves it untouched
    always_ff @(posedge clk_sys) begin
        hours_reg <= hours_next;
        min_reg <= min_next;
        sec_reg <= sec_next;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            load_q_reg <= 1'b0;
            thr_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            load_q_reg <= bus.load;
            thr_reg <= bus.dir ? (hours_ext <= bus.ref_val) :
                (hours_ext >= bus.ref_val);
            zero_reg <= at_zero;
        end
    end

    assign bus.hours = hours_reg;
    assign bus.minutes = min_reg;
    assign bus.seconds = sec_reg;
    assign bus.thr = thr_reg;
    assign bus.zero = zero_reg;

    // ==========================================================
    // Checks
    clear_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        bus.clear |=> at_zero)
        else $error("count not zero after clear");
    hold_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        bus.gate && !bus.enable && !bus.clear && !load_rise
        |=> $stable(hours_reg) && $stable(sec_reg) && $stable(min_reg))
        else $error("count moved while disabled");
    no_run_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !bus.run && !bus.clear && !load_rise |=> $stable(sec_reg))
        else $error("count moved while program stopped");
    load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        load_rise && !bus.clear && bus.preset < 32'h00001000
        |=> hours_reg == $past(bus.preset[19:0]) && sec_reg == 6'h00)
        else $error("preset not loaded");
    up_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        step && !bus.dir && !bus.clear && !load_rise && sec_reg < 6'h3b
        |=> sec_reg == $past(sec_reg) + 6'h01)
        else $error("second did not advance");
    sat_up_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        at_max && !bus.dir && !bus.clear && !load_rise |=> at_max)
        else $error("count wrapped at top");
    thr_up_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !bus.dir && hours_ext >= bus.ref_val |=> thr_reg)
        else $error("threshold missed counting up");
    thr_dn_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        bus.dir && hours_ext > bus.ref_val |=> !thr_reg)
        else $error("threshold held counting down");
    zero_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !at_zero ##1 at_zero |=> zero_reg)
        else $error("zero flag missed");
    gate_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !bus.gate && !bus.enable && bus.run && bus.tick && !bus.dir &&
        !bus.clear && !load_rise && sec_reg < 6'h3b |=> !$stable(sec_reg))
        else $error("enable not ignored when gate off");
endmodule

/* File: test/ohc_axi_master.sv */
`timescale 1ns/100ps
// ==========================================================
// Program side: register master
module ohc_axi_master (
    input wire logic clk_sys,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
            output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

/* File: test/operating_hours_counter_bench.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("wrong value %s exp %h got %h", n, e, g); \
        end \
    end
module operating_hours_counter_bench;
    logic clk_sys = 0;
    logic nrst = 0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, s;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, irq;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] rv [6] = '{3, 5, 6, 6, 5, 4};
    logic te [6] = '{1, 1, 0, 1, 1, 0};
    always #5 clk_sys = ~clk_sys;
    ohc_top #(.STEP_CYCLES(4)) dut (.*);
    ohc_axi_master m (.*);
    function automatic logic [7:0] ca(input int i, input logic [4:0] o);
        return 8'((i + 1) * 32) + {3'h0, o};
    endfunction
    task automatic rc(input string n, input logic [7:0] a,
            input logic [31:0] e, input logic [31:0] k = 32'hffffffff);
        m.rd(a, d, r);
        `CHK(n, e, d & k)
        `CHK("rresp", ohc_pkg::RESP_OKAY, r)
    endtask
    task automatic ld(input int i, input logic [31:0] v,
            input logic [4:0] c);
        m.wr(ca(i, ohc_pkg::OFS_PRESET), v);
        m.wr(ca(i, ohc_pkg::OFS_CTRL), {27'h0, c});
        m.wr(ca(i, ohc_pkg::OFS_CTRL), {27'h0, c | 5'h08});
    endtask
    task automatic clr(input int i, input logic [4:0] c);
        m.wr(ca(i, ohc_pkg::OFS_CTRL), {27'h0, c | 5'h04});
        repeat (2) @(posedge clk_sys);
        m.wr(ca(i, ohc_pkg::OFS_CTRL), {27'h0, c});
    endtask
    task automatic final_report();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rc("gctrl", ohc_pkg::OFS_GCTRL, 32'h0);
        rc("ctrl", ca(0, ohc_pkg::OFS_CTRL), 32'h10);
        m.rd(8'hfc, d, r);
        `CHK("resp", ohc_pkg::RESP_SLVERR, r)
        m.wr(8'hfc, 32'h1);
        `CHK("bresp", ohc_pkg::RESP_SLVERR, s_axi_bresp)
        m.wr(ohc_pkg::OFS_IRQ_MASK, 32'h0);
        `CHK("bresp", ohc_pkg::RESP_OKAY, s_axi_bresp)
        for (int i = 0; i < 4; i++) begin
            clr(i, 5'h10);
            rc("zero", ca(i, ohc_pkg::OFS_FLAGS), 32'h2, 32'h2);
        end
        for (int i = 0; i < 4; i++) ld(i, i + 2, 5'h10);
        for (int i = 0; i < 4; i++) begin
            rc("hours", ca(i, ohc_pkg::OFS_HOURS), i + 2);
        end
        m.wr(ca(0, ohc_pkg::OFS_CTRL), 32'h11);
        repeat (40) @(posedge clk_sys);
        rc("stopped", ca(0, ohc_pkg::OFS_MINSEC), 32'h0);
        m.wr(ca(0, ohc_pkg::OFS_CTRL), 32'h10);
        m.wr(ohc_pkg::OFS_GCTRL, 32'h1);
        repeat (40) @(posedge clk_sys);
        rc("disabled", ca(0, ohc_pkg::OFS_MINSEC), 32'h0);
        m.wr(ca(0, ohc_pkg::OFS_CTRL), 32'h0);
        repeat (40) @(posedge clk_sys);
        m.rd(ca(0, ohc_pkg::OFS_MINSEC), d, r);
        `CHK("ungated", 1'b1, d != 0)
        m.wr(ohc_pkg::OFS_GCTRL, 32'h0);
        m.rd(ca(0, ohc_pkg::OFS_MINSEC), s, r);
        repeat (40) @(posedge clk_sys);
        rc("held", ca(0, ohc_pkg::OFS_MINSEC), s);
        ld(0, 5, 5'h10);
        for (int k = 0; k < 6; k++) begin
            m.wr(ca(0, ohc_pkg::OFS_CTRL), k < 3 ? 32'h18 : 32'h1a);
            m.wr(ca(0, ohc_pkg::OFS_REF), rv[k]);
            rc("thr", ca(0, ohc_pkg::OFS_FLAGS), te[k], 32'h1);
        end
        m.wr(ohc_pkg::OFS_IRQ_STAT, 32'hff);
        m.wr(ohc_pkg::OFS_IRQ_MASK, 32'h2);
        clr(0, 5'h10);
        `CHK("irq", 1'b1, irq)
        m.wr(ohc_pkg::OFS_IRQ_MASK, 32'h0);
        `CHK("irq", 1'b0, irq)
        rc("stat", ohc_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
        m.wr(ohc_pkg::OFS_IRQ_STAT, 32'h2);
        rc("stat", ohc_pkg::OFS_IRQ_STAT, 32'h0, 32'h2);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rc("kept", ca(1, ohc_pkg::OFS_HOURS), 32'h3);
        m.wr(ohc_pkg::OFS_GCTRL, 32'h1);
        ld(0, {12'h0, ohc_pkg::HOURS_MAX}, 5'h11);
        repeat (14800) @(posedge clk_sys);
        rc("hmax", ca(0, ohc_pkg::OFS_HOURS), 32'h91a2b);
        rc("msmax", ca(0, ohc_pkg::OFS_MINSEC), 32'h3b3b);
        ld(0, 1, 5'h13);
        repeat (40) @(posedge clk_sys);
        rc("hdown", ca(0, ohc_pkg::OFS_HOURS), 32'h0);
        rc("borrow", ca(0, ohc_pkg::OFS_MINSEC), 32'h3b00, 32'h3f00);
        ld(0, 0, 5'h13);
        repeat (40) @(posedge clk_sys);
        rc("floor", ca(0, ohc_pkg::OFS_MINSEC), 32'h0);
        rc("zero", ca(0, ohc_pkg::OFS_FLAGS), 32'h2, 32'h2);
        final_report();
    end
endmodule
